// ### core/sisg_core.sv
// interrupt status, masks and pin drive for the sensor system registers
// Overview of operation
// R1: status upper byte reports FIFO byte count
// R2: byte count halved before word threshold compare
// R3: writing bit 15 empties the FIFO
// R4: reserved status bit 7 reads zero
// R5: second slot flag set, write-one clears
// R6: first slot flag set, write-one clears
// R7: reserved low status bits read zero
// R8: mask bit 8 gates FIFO interrupt, resets masked
// R9: mask bit 6 gates second slot, resets masked
// R10: mask bit 5 gates first slot, resets masked
// R11: second pin drive 0 drives continuously
// R12: second pin drive 1 is open drain
// R13: second pin polarity bit selects active level
// R14: first pin enable 0 floats the pin
// R15: FIFO interrupt while words exceed threshold
// R16: first pin drive and polarity select
// R17: interrupt asserts on any unmasked pending condition
// R18: slot flags set regardless of mask
`default_nettype none
module sisg_core (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // register access from the serial control port
  input wire sisg_pkg::sisg_req_s req,
  output logic [sisg_pkg::DATA_W-1:0] rdData,
  output logic rdValid,
  // sample sequencer and FIFO
  input wire logic firstSlotSample,
  input wire logic secondSlotSample,
  input wire logic [sisg_pkg::CNT_W-1:0] fifoByteCount,
  output logic fifoClear,
  // general pins, enable low while driving
  output logic firstPinOut,
  output logic firstPinOeB,
  output logic secondPinOut,
  output logic secondPinOeB,
  output logic irq
);
  import sisg_pkg::*;

  // event flags, set by the sequencer and cleared by host write-one
  logic firstFlag_r, firstFlag_nxt;
  logic secondFlag_r, secondFlag_nxt;
  // configuration registers
  logic [DATA_W-1:0] mask_r, mask_nxt;
  logic [DATA_W-1:0] pinCfg_r, pinCfg_nxt;
  logic [TH_W-1:0] thresh_r, thresh_nxt;
  // read answer
  logic [DATA_W-1:0] rdData_r, rdData_nxt;
  logic rdValid_r, rdValid_nxt;
  // FIFO clear strobe
  logic fifoClear_r, fifoClear_nxt;
  // registered pin drive
  sisg_pin_s pin1_r, pin1_nxt;
  sisg_pin_s pin2_r, pin2_nxt;
  // decoded write strobes
  logic wrStatus;
  logic wrMask;
  logic wrPinCfg;
  logic wrThresh;
  // interrupt sources
  logic fifoOver;
  logic fifoPend;
  logic firstPend;
  logic secondPend;
  logic irqNow;
  // assembled read views
  logic [DATA_W-1:0] statusWord;
  logic [DATA_W-1:0] threshWord;

  // write strobe aimed at one register offset
  function automatic logic wrHit(input sisg_req_s r,
                                 input logic [ADDR_W-1:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction

  // write-one-to-clear update of one event flag, set wins over clear
  function automatic logic flagNext(input logic cur, input logic setEv,
                                    input logic clrHit);
    logic n;
    n = cur & ~clrHit;
    if (setEv)
    begin
      n = 1'b1;
    end
    return n;
  endfunction

  // pin drive from interrupt state, drive mode and polarity
  function automatic sisg_pin_s pinDrive(input logic ena, input logic drv,
                                         input logic pol, input logic act);
    sisg_pin_s p;
    p.level = act ^ pol;
    p.oeB = ~ena | (drv & ~act);
    return p;
  endfunction

  // request decode
  always_comb
  begin
    wrStatus = wrHit(req, OFS_STATUS);
    wrMask = wrHit(req, OFS_MASK);
    wrPinCfg = wrHit(req, OFS_PINCFG);
    wrThresh = wrHit(req, OFS_THRESH);
  end

  // interrupt sources and combined request
  always_comb
  begin
    // R2: bytes to words
    // R15: over threshold
    fifoOver = fifoByteCount[CNT_W-1:1] > {1'b0, thresh_r};
    // R8: fifo mask gate
    fifoPend = fifoOver & ~mask_r[MK_FIFO_BIT];
    // R9: second slot gate
    secondPend = secondFlag_r & ~mask_r[MK_B_BIT];
    // R10: first slot gate
    firstPend = firstFlag_r & ~mask_r[MK_A_BIT];
    // R17: unmasked pending
    irqNow = fifoPend | secondPend | firstPend;
  end

  // event flag next state
  always_comb
  begin
    // R18: set ignores mask
    // R6: first slot clear
    firstFlag_nxt = flagNext(firstFlag_r, firstSlotSample,
                             wrStatus & req.wdata[ST_A_BIT]);
    // R5: second slot clear
    secondFlag_nxt = flagNext(secondFlag_r, secondSlotSample,
                              wrStatus & req.wdata[ST_B_BIT]);
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      firstFlag_r <= 1'b0;
      secondFlag_r <= 1'b0;
    end
    else
    begin
      firstFlag_r <= firstFlag_nxt;
      secondFlag_r <= secondFlag_nxt;
    end
  end

  // FIFO clear strobe next state
  always_comb
  begin
    // R3: FIFO clear strobe
    fifoClear_nxt = wrStatus & req.wdata[ST_CLR_BIT];
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      fifoClear_r <= 1'b0;
    end
    else
    begin
      fifoClear_r <= fifoClear_nxt;
    end
  end

  // configuration register next state
  always_comb
  begin
    mask_nxt = mask_r;
    pinCfg_nxt = pinCfg_r;
    thresh_nxt = thresh_r;
    if (wrMask)
    begin
      mask_nxt = req.wdata;
    end
    if (wrPinCfg)
    begin
      pinCfg_nxt = req.wdata;
    end
    if (wrThresh)
    begin
      thresh_nxt = req.wdata[TH_LSB +: TH_W];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      mask_r <= MASK_RST;
      pinCfg_r <= PINCFG_RST;
      thresh_r <= THRESH_RST;
    end
    else
    begin
      mask_r <= mask_nxt;
      pinCfg_r <= pinCfg_nxt;
      thresh_r <= thresh_nxt;
    end
  end

  // read views of the status and threshold registers
  always_comb
  begin
    statusWord = '0;
    // R1: byte count field
    statusWord[ST_CNT_LSB +: CNT_W] = fifoByteCount;
    statusWord[ST_B_BIT] = secondFlag_r;
    statusWord[ST_A_BIT] = firstFlag_r;
    // R4: bit 7 zero
    statusWord[ST_RSV_BIT] = 1'b0;
    // R7: low bits zero
    statusWord[ST_LOW_MSB:0] = '0;
    threshWord = '0;
    threshWord[TH_LSB +: TH_W] = thresh_r;
  end

  // read answer next state
  always_comb
  begin
    rdValid_nxt = req.rd;
    rdData_nxt = rdData_r;
    if (req.rd)
    begin
      case (req.addr)
        OFS_STATUS:
        begin
          rdData_nxt = statusWord;
        end
        OFS_MASK:
        begin
          rdData_nxt = mask_r;
        end
        OFS_PINCFG:
        begin
          rdData_nxt = pinCfg_r;
        end
        OFS_THRESH:
        begin
          rdData_nxt = threshWord;
        end
        default:
        begin
          rdData_nxt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      rdData_r <= '0;
      rdValid_r <= 1'b0;
    end
    else
    begin
      rdData_r <= rdData_nxt;
      rdValid_r <= rdValid_nxt;
    end
  end

  // pin drive next state, one cycle behind the interrupt
  always_comb
  begin
    // R14: enable gates pin
    // R16: first pin mode
    pin1_nxt = pinDrive(pinCfg_r[PC_ENA1_BIT], pinCfg_r[PC_DRV1_BIT],
                        pinCfg_r[PC_POL1_BIT], irqNow);
    // R11: continuous drive
    // R12: open drain
    // R13: polarity select
    pin2_nxt = pinDrive(1'b1, pinCfg_r[PC_DRV2_BIT],
                        pinCfg_r[PC_POL2_BIT], irqNow);
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      pin1_r <= '{level: 1'b0, oeB: 1'b1};
      pin2_r <= '{level: 1'b0, oeB: 1'b0};
    end
    else
    begin
      pin1_r <= pin1_nxt;
      pin2_r <= pin2_nxt;
    end
  end

  assign rdData = rdData_r;
  assign rdValid = rdValid_r;
  assign fifoClear = fifoClear_r;
  assign firstPinOut = pin1_r.level;
  assign firstPinOeB = pin1_r.oeB;
  assign secondPinOut = pin2_r.level;
  assign secondPinOeB = pin2_r.oeB;
  assign irq = irqNow;
endmodule
`default_nettype wire

// ### core/sisg_pkg.sv
// constants and carrier types for the sensor interrupt status block
`default_nettype none
package sisg_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  // register offsets
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h01;
  localparam logic [ADDR_W-1:0] OFS_PINCFG = 8'h02;
  localparam logic [ADDR_W-1:0] OFS_THRESH = 8'h06;
  // status register fields
  localparam int ST_CNT_LSB = 8;
  localparam int ST_CLR_BIT = 15;
  localparam int ST_RSV_BIT = 7;
  localparam int ST_B_BIT = 6;
  localparam int ST_A_BIT = 5;
  localparam int ST_LOW_MSB = 4;
  // mask register fields
  localparam int MK_FIFO_BIT = 8;
  localparam int MK_B_BIT = 6;
  localparam int MK_A_BIT = 5;
  localparam logic [DATA_W-1:0] MASK_RST = 16'h01FF;
  // pin configuration fields
  localparam int PC_DRV2_BIT = 9;
  localparam int PC_POL2_BIT = 8;
  localparam int PC_ENA1_BIT = 2;
  localparam int PC_DRV1_BIT = 1;
  localparam int PC_POL1_BIT = 0;
  localparam logic [DATA_W-1:0] PINCFG_RST = 16'h0000;
  // threshold field, in words
  localparam int TH_LSB = 8;
  localparam int TH_W = 6;
  localparam logic [TH_W-1:0] THRESH_RST = 6'h00;
  localparam int CNT_W = 8;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sisg_req_s;

  typedef struct packed {
    logic level;
    logic oeB;
  } sisg_pin_s;
endpackage
`default_nettype wire

// ### core/sisg_unused_guard.sv
// intentionally empty companion file
`default_nettype none
`default_nettype wire

// ### testbench/sisg_core_properties.sv
// port checker for the sensor interrupt status block
`default_nettype none
module sisg_core_chk (
  // watched ports
  input wire logic clock,
  input wire logic rst_b,
  input wire sisg_pkg::sisg_req_s req,
  input wire logic [15:0] rdData,
  input wire logic firstSlotSample,
  input wire logic secondSlotSample,
  input wire logic [7:0] fifoByteCount,
  input wire logic fifoClear,
  input wire logic secondPinOeB,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_rd0; req.rd && req.addr == 8'h00; endsequence
  sequence s_clr6; req.wr && req.addr == 8'h00 && req.wdata[6]; endsequence
  property p_cnt; s_rd0 |=> rdData[15:8] == $past(fifoByteCount); endproperty
  a_cnt: assert property (p_cnt) else $error("cnt");
  property p_rsv; s_rd0 |=> (rdData & 16'h009F) == 16'h0000; endproperty
  a_rsv: assert property (p_rsv) else $error("rsv");
  property p_clr;
    fifoClear == $past(req.wr && req.addr == 8'h00 && req.wdata[15]);
  endproperty
  a_clr: assert property (p_clr) else $error("clr");
  property p_setA; firstSlotSample ##1 !req.wr ##1 s_rd0 |=> rdData[5];
  endproperty
  a_setA: assert property (p_setA) else $error("setA");
  property p_setB; secondSlotSample ##1 !req.wr ##1 s_rd0 |=> rdData[6];
  endproperty
  a_setB: assert property (p_setB) else $error("setB");
  property p_clrB;
    s_clr6 ##0 !secondSlotSample [*2] ##1 s_rd0 |=> !rdData[6];
  endproperty
  a_clrB: assert property (p_clrB) else $error("clrB");
  property p_od; secondPinOeB |-> !$past(irq); endproperty
  a_od: assert property (p_od) else $error("od");
  property p_irq; $changed(irq) |-> $changed(fifoByteCount) ||
    $past(firstSlotSample || secondSlotSample || req.wr); endproperty
  a_irq: assert property (p_irq) else $error("irq");
endmodule
bind sisg_core sisg_core_chk i_sisg_core_chk (.clock, .rst_b, .req, .rdData,
  .firstSlotSample, .secondSlotSample, .fifoByteCount, .fifoClear,
  .secondPinOeB, .irq);
`default_nettype wire

// ### testbench/sisg_core_tb.sv
// self-checking bench for the sensor interrupt status block
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
  $display("ERROR %0t bad", $time); end end
module sisg_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rst_b = 0, firstSlotSample = 0, secondSlotSample = 0;
  logic rdValid, fifoClear, firstPinOut, firstPinOeB, secondPinOut;
  logic secondPinOeB, irq;
  logic [15:0] rdData, q[$];
  logic [7:0] fifoByteCount = 0, c;
  sisg_pkg::sisg_req_s req;
  int failures = 0, cmp_count = 0, cyc = 0, clrSeen = 0;
  always #2 clock = ~clock;
  sisg_host i_sisg_host (.clock, .req);
  sisg_core i_sisg_core (.clock, .rst_b, .req, .rdData, .rdValid,
    .firstSlotSample, .secondSlotSample, .fifoByteCount, .fifoClear,
    .firstPinOut, .firstPinOeB, .secondPinOut, .secondPinOeB, .irq);
  task automatic end_sim();
    if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic op(logic w, logic [7:0] a, logic [15:0] d);
    @(posedge clock);
    if (!w) q.push_back(d);
    i_sisg_host.acc(w, a, d);
  endtask
  task automatic pls(logic b, int n);
    @(posedge clock);
    {secondSlotSample, firstSlotSample} <= {b, !b};
    @(posedge clock);
    {secondSlotSample, firstSlotSample} <= 2'b00;
    repeat (n) @(posedge clock);
  endtask
  always @(posedge clock)
  begin
    cyc++;
    if (fifoClear === 1'b1) clrSeen++;
    if (rdValid === 1'b1) `CHK(rdData, q.pop_front())
    if (cyc == 1000)
    begin
      failures++;
      end_sim();
    end
  end
  initial
  begin
    void'($urandom(27));
    c = 8'($urandom());
    repeat (6) @(posedge clock);
    rst_b <= 1;
    fifoByteCount <= c;
    op(0, 8'h01, 16'h01FF);
    op(0, 8'h02, 16'h0000);
    op(0, 8'h03, 16'h0000);
    pls(0, 0);
    op(0, 8'h00, {c, 8'h20});
    pls(1, 0);
    op(0, 8'h00, {c, 8'h60});
    op(1, 8'h00, 16'h0020);
    op(0, 8'h00, {c, 8'h40});
    op(1, 8'h00, 16'h80FF);
    op(0, 8'h00, {c, 8'h00});
    op(1, 8'h01, 16'h01DF);
    pls(0, 2);
    `CHK({irq, secondPinOeB, secondPinOut, firstPinOeB}, 4'hB)
    op(1, 8'h02, 16'h0307);
    repeat (2) @(posedge clock);
    `CHK({secondPinOeB, secondPinOut, firstPinOeB, firstPinOut}, 4'h0)
    op(1, 8'h00, 16'h0020);
    repeat (2) @(posedge clock);
    `CHK({irq, secondPinOeB, firstPinOeB}, 3'h3)
    op(1, 8'h01, 16'h00FF);
    op(1, 8'h06, 16'h0300);
    for (int i = 7; i < 9; i++)
    begin
      fifoByteCount <= 8'(i);
      @(posedge clock);
      `CHK(irq, i == 8)
    end
    op(1, 8'h01, 16'h01FF);
    @(posedge clock);
    `CHK(irq, 1'b0)
    `CHK(clrSeen, 1)
    end_sim();
  end
endmodule
`default_nettype wire

// ### testbench/sisg_host.sv
// host model on the register port
`default_nettype none
module sisg_host (
  // register requests
  input wire logic clock,
  output var sisg_pkg::sisg_req_s req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  task automatic acc(logic w, logic [7:0] a, logic [15:0] d);
    req <= '{w, !w, a, d};
    @(posedge clock);
    req <= '{1'b0, 1'b0, ~a, ~d};
  endtask
endmodule
`default_nettype wire
